// [design/fdm_map.svh]
`ifndef FDM_MAP_SVH
`define FDM_MAP_SVH

// register offsets (byte addresses)
`define FDM_ADDR_W 8
`define FDM_OFF_CTRL 8'h00
`define FDM_OFF_VOUT 8'h04
`define FDM_OFF_STATE 8'h08
`define FDM_OFF_IRQ_STATUS 8'h0c
`define FDM_OFF_IRQ_CLEAR 8'h10
`define FDM_OFF_IRQ_ENABLE 8'h14

// control register fields
`define FDM_CTRL_MODE_LSB 0
`define FDM_CTRL_FORCE_BIT 2
`define FDM_CTRL_LIMIT_BIT 3
`define FDM_CTRL_DUR_LSB 4
`define FDM_CTRL_RESET 7'h00
`define FDM_VOUT_RESET 4'h0
`define FDM_IRQ_ENABLE_RESET 3'h0

// event bits of the interrupt registers
`define FDM_EV_SHORT 0
`define FDM_EV_OPEN 1
`define FDM_EV_TIMEOUT 2
`define FDM_EV_W 3

// over-voltage threshold boundary: codes at or below use the low threshold
`define FDM_OV_LOW_MAX 4'h4

// valley current limit settings in mA
`define FDM_VALLEY_LIMIT_SELECT_W 11
`define FDM_VALLEY_LIMIT_SELECT_DIRECT_LO 11'h47e
`define FDM_VALLEY_LIMIT_SELECT_DIRECT_HI 11'h640
`define FDM_VALLEY_LIMIT_SELECT_STORE_LO 11'h01e
`define FDM_VALLEY_LIMIT_SELECT_STORE_HI 11'h0fa
`define FDM_VALLEY_LIMIT_SELECT_NONE 11'h000

// timing: system clock, internal oscillator, safety timer step
`define FDM_CLK_HZ 100000000
`define FDM_OSC_HZ 2000000
`define FDM_OSC_DIV (`FDM_CLK_HZ / `FDM_OSC_HZ)
`define FDM_DIV_W 6
`define FDM_STEP_NS 50000
`define FDM_STEP_TICKS ((`FDM_STEP_NS * (`FDM_OSC_HZ / 1000)) / 1000000)
`define FDM_TMR_W 10

`endif

// [design/fdm_pkg.sv]
`default_nettype none
package fdm_pkg;
	// operating modes decoded from the mode field and the force bit
	typedef enum logic [2:0] {
		op_off,
		op_cm_dc,
		op_cm_flash,
		op_vm_only,
		op_vm_dc,
		op_vm_flash
	} fdm_op_e;
	typedef logic [2:0] fdm_dur_t;
endpackage : fdm_pkg
`default_nettype wire

// [design/fdm_tmr_if.sv]
`default_nettype none
interface fdm_tmr_if;
	logic osc_tick;
	logic start;
	logic abort;
	fdm_pkg::fdm_dur_t dur;
	logic running;
	logic expire;
	modport ctrl (output osc_tick, output start, output abort, output dur,
		input running, input expire);
	modport tmr (input osc_tick, input start, input abort, input dur,
		output running, output expire);
endinterface : fdm_tmr_if
`default_nettype wire

// [design/fdm_safety_timer.sv]
`include "fdm_map.svh"
`default_nettype none
module fdm_safety_timer (
	input wire logic clock_i, // system clock
	input wire logic rstn_i, // async reset, active low
	fdm_tmr_if.tmr tmr // control side
);
	logic [`FDM_TMR_W-1:0] cnt_ff;
	logic run_ff;
	logic exp_ff;

	// length in oscillator ticks for a duration code
	function automatic logic [`FDM_TMR_W-1:0] dur_ticks(input fdm_pkg::fdm_dur_t d);
		dur_ticks = `FDM_TMR_W'((d + 4'h1) * `FDM_STEP_TICKS);
	endfunction : dur_ticks

	assign tmr.running = run_ff;
	assign tmr.expire = exp_ff;

	////////////////////////////////////////////////////////////////////////
	// counts only oscillator ticks, so duration scales with oscillator rate
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else begin
			exp_ff <= 1'b0;
			if (tmr.abort) begin
				run_ff <= 1'b0;
			end else if (tmr.start && !run_ff) begin
				cnt_ff <= dur_ticks(tmr.dur);
				run_ff <= 1'b1;
			end else if (run_ff && tmr.osc_tick) begin
				if (cnt_ff == `FDM_TMR_W'(1)) begin
					run_ff <= 1'b0;
					exp_ff <= 1'b1;
				end
				cnt_ff <= cnt_ff - `FDM_TMR_W'(1);
			end
		end
	end
endmodule : fdm_safety_timer
`default_nettype wire

// [design/fdm_top.sv]
// Overview of operation
// - flash safety timer counts internal oscillator ticks, so duration tracks its rate.
// - valley limit select may change only in the initial shutdown state.
// - storage mode low: valley limit 1150 mA or 1600 mA by select bit.
// - storage mode high, blanking low: valley limit 30 mA or 250 mA.
// - storage mode high and blanking high: power stage disabled.
// - shorted LED: keep low-side current limiting and set the failure flag.
// - open LED: clamp output at the active over-voltage threshold, set failure flag.
// - storage mode low and voltage code 0000..0100: lower over-voltage threshold.
// - storage mode high or voltage code 0101..1111: higher over-voltage threshold.
// - mode 00, force 0: shut converter down, disconnect load.
// - mode 01, force 0: DC light in current regulation.
// - mode 10, force 0: current regulation with LEDs armed for flash.
// - flash-armed current mode with storage high: stage off during strobe.
// - mode 11, or 00 with force 1: LEDs off, voltage regulation.
// - mode 01, force 1: voltage regulation plus DC light through sinks.
// - mode 10, force 1: voltage regulation, LEDs armed for flash.
// - voltage flash-armed with storage high: stage stays active in strobe.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "fdm_map.svh"
`default_nettype none
module fdm_top (
	input wire logic clock_i, // system clock, 100 MHz
	input wire logic rstn_i, // async reset, active low
	input wire logic [`FDM_ADDR_W-1:0] addr_i, // register address
	input wire logic [31:0] wdata_i, // register write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [31:0] rdata_o, // read data, cycle after rd_i
	input wire logic storage_cap_mode_input_i, // storage capacitor mode
	input wire logic blank_i, // transmit blanking input
	input wire logic strobe_i, // flash strobe request level
	input wire logic led_short_i, // LED short detected
	input wire logic led_open_i, // LED open detected
	output logic shutdown_o, // converter shut down
	output logic load_connect_o, // load connected to battery
	output logic current_regulation_mode_o, // current regulation
	output logic voltage_regulation_mode_o, // voltage regulation
	output logic led_enable_o, // low-side sinks enabled
	output logic flash_armed_o, // LEDs armed for flash
	output logic flash_drive_o, // LEDs at flash level
	output logic stage_enable_o, // inductive power stage on
	output logic [`FDM_VALLEY_LIMIT_SELECT_W-1:0] valley_limit_ma_o, // valley limit in mA
	output logic ovp_high_sel_o, // higher over-voltage threshold
	output logic overvoltage_clamp_o, // secondary clamp loop on
	output logic sink_limit_o, // low-side current limiting held
	output logic led_failure_flag_o, // LED failure flag
	output logic irq_o // interrupt, level
);
	////////////////////////////////////////////////////////////////////////
	// register state
	logic [1:0] mode_ff;
	logic force_voltage_regulation_ff;
	logic valley_limit_select_ff;
	fdm_pkg::fdm_dur_t flash_duration_field_ff;
	logic [3:0] output_voltage_code_ff;
	logic initial_shutdown_ff;
	logic [`FDM_EV_W-1:0] irq_status_ff;
	logic [`FDM_EV_W-1:0] irq_enable_ff;
	logic [31:0] rdata_ff;
	logic strobe_d_ff;
	logic [`FDM_DIV_W-1:0] div_ff;
	logic osc_tick_ff;

	logic wr_ctrl;
	logic wr_vout;
	logic wr_clear;
	logic wr_enable;
	fdm_pkg::fdm_op_e op;
	logic [`FDM_EV_W-1:0] events;

	fdm_tmr_if tmr_bus ();

	// decode of mode field and force bit
	function automatic fdm_pkg::fdm_op_e op_decode(input logic [1:0] m, input logic f);
		fdm_pkg::fdm_op_e r;
		r = fdm_pkg::op_off;
		unique case ({f, m})
			3'h0: r = fdm_pkg::op_off;
			3'h1: r = fdm_pkg::op_cm_dc;
			3'h2: r = fdm_pkg::op_cm_flash;
			3'h3: r = fdm_pkg::op_vm_only;
			3'h4: r = fdm_pkg::op_vm_only;
			3'h5: r = fdm_pkg::op_vm_dc;
			3'h6: r = fdm_pkg::op_vm_flash;
			3'h7: r = fdm_pkg::op_vm_only;
		endcase
		return r;
	endfunction : op_decode

	function automatic logic addr_hit(input logic [`FDM_ADDR_W-1:0] a,
		input logic [`FDM_ADDR_W-1:0] off);
		return a == off;
	endfunction : addr_hit

	assign wr_ctrl = wr_i && addr_hit(addr_i, `FDM_OFF_CTRL);
	assign wr_vout = wr_i && addr_hit(addr_i, `FDM_OFF_VOUT);
	assign wr_clear = wr_i && addr_hit(addr_i, `FDM_OFF_IRQ_CLEAR);
	assign wr_enable = wr_i && addr_hit(addr_i, `FDM_OFF_IRQ_ENABLE);
	assign op = op_decode(mode_ff, force_voltage_regulation_ff);

	////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_ff <= 2'h0;
			force_voltage_regulation_ff <= 1'b0;
			flash_duration_field_ff <= 3'h0;
		end else if (wr_ctrl) begin
			mode_ff <= wdata_i[`FDM_CTRL_MODE_LSB +: 2];
			force_voltage_regulation_ff <= wdata_i[`FDM_CTRL_FORCE_BIT];
			flash_duration_field_ff <= wdata_i[`FDM_CTRL_DUR_LSB +: 3];
		end
	end

	// limit select only accepted before any operating mode was entered
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			valley_limit_select_ff <= 1'b0;
		end else if (wr_ctrl && initial_shutdown_ff) begin
			valley_limit_select_ff <= wdata_i[`FDM_CTRL_LIMIT_BIT];
		end
	end

	// initial shutdown ends for good once a mode other than shutdown runs
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			initial_shutdown_ff <= 1'b1;
		end else if (op != fdm_pkg::op_off) begin
			initial_shutdown_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			output_voltage_code_ff <= `FDM_VOUT_RESET;
		end else if (wr_vout) begin
			output_voltage_code_ff <= wdata_i[3:0];
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_enable_ff <= `FDM_IRQ_ENABLE_RESET;
		end else if (wr_enable) begin
			irq_enable_ff <= wdata_i[`FDM_EV_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal oscillator: one-cycle tick from a divider
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_ff <= '0;
			osc_tick_ff <= 1'b0;
		end else begin
			osc_tick_ff <= 1'b0;
			if (div_ff == `FDM_DIV_W'(`FDM_OSC_DIV - 1)) begin
				div_ff <= '0;
				osc_tick_ff <= 1'b1;
			end else begin
				div_ff <= div_ff + `FDM_DIV_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flash safety timer
	logic armed;

	assign armed = (op == fdm_pkg::op_cm_flash) || (op == fdm_pkg::op_vm_flash);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_d_ff <= 1'b0;
		end else begin
			strobe_d_ff <= strobe_i;
		end
	end

	assign tmr_bus.osc_tick = osc_tick_ff;
	assign tmr_bus.start = armed && strobe_i && !strobe_d_ff;
	assign tmr_bus.abort = !armed || !strobe_i;
	assign tmr_bus.dur = flash_duration_field_ff;

	fdm_safety_timer u_timer (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.tmr(tmr_bus.tmr)
	);

	////////////////////////////////////////////////////////////////////////
	// events and interrupt; a new event wins over a clear in the same cycle
	assign events[`FDM_EV_SHORT] = led_short_i;
	assign events[`FDM_EV_OPEN] = led_open_i;
	assign events[`FDM_EV_TIMEOUT] = tmr_bus.expire;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_status_ff <= '0;
		end else begin
			irq_status_ff <= (irq_status_ff & ~({`FDM_EV_W{wr_clear}} &
				wdata_i[`FDM_EV_W-1:0])) | events;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status_ff & irq_enable_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode outputs
	logic nxt_shutdown;
	logic nxt_cm;
	logic nxt_vm;
	logic nxt_led_enable;
	logic nxt_flash_drive;
	logic nxt_stage_enable;

	always_comb begin
		nxt_shutdown = 1'b0;
		nxt_cm = 1'b0;
		nxt_vm = 1'b0;
		nxt_led_enable = 1'b0;
		unique case (op)
			fdm_pkg::op_off: begin
				nxt_shutdown = 1'b1;
			end
			fdm_pkg::op_cm_dc, fdm_pkg::op_cm_flash: begin
				nxt_cm = 1'b1;
				nxt_led_enable = 1'b1;
			end
			fdm_pkg::op_vm_only: begin
				nxt_vm = 1'b1;
			end
			fdm_pkg::op_vm_dc, fdm_pkg::op_vm_flash: begin
				nxt_vm = 1'b1;
				nxt_led_enable = 1'b1;
			end
		endcase
	end

	assign nxt_flash_drive = armed && strobe_i && tmr_bus.running;

	// power stage on unless shut down, blanked in storage mode, or
	// strobing from the storage capacitor in current mode
	always_comb begin
		nxt_stage_enable = !nxt_shutdown;
		if (storage_cap_mode_input_i && blank_i) begin
			nxt_stage_enable = 1'b0;
		end else if (op == fdm_pkg::op_cm_flash && storage_cap_mode_input_i &&
			nxt_flash_drive) begin
			nxt_stage_enable = 1'b0;
		end
		// voltage flash mode leaves the stage running through the strobe
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shutdown_o <= 1'b1;
			load_connect_o <= 1'b0;
			current_regulation_mode_o <= 1'b0;
			voltage_regulation_mode_o <= 1'b0;
			led_enable_o <= 1'b0;
			flash_armed_o <= 1'b0;
			flash_drive_o <= 1'b0;
			stage_enable_o <= 1'b0;
		end else begin
			shutdown_o <= nxt_shutdown;
			load_connect_o <= !nxt_shutdown;
			current_regulation_mode_o <= nxt_cm;
			voltage_regulation_mode_o <= nxt_vm;
			led_enable_o <= nxt_led_enable;
			flash_armed_o <= armed;
			flash_drive_o <= nxt_flash_drive;
			stage_enable_o <= nxt_stage_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// valley current limit
	logic [`FDM_VALLEY_LIMIT_SELECT_W-1:0] nxt_valley_limit;

	always_comb begin
		if (!storage_cap_mode_input_i) begin
			nxt_valley_limit = valley_limit_select_ff ? `FDM_VALLEY_LIMIT_SELECT_DIRECT_HI :
				`FDM_VALLEY_LIMIT_SELECT_DIRECT_LO;
		end else if (!blank_i) begin
			nxt_valley_limit = valley_limit_select_ff ? `FDM_VALLEY_LIMIT_SELECT_STORE_HI :
				`FDM_VALLEY_LIMIT_SELECT_STORE_LO;
		end else begin
			nxt_valley_limit = `FDM_VALLEY_LIMIT_SELECT_NONE;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			valley_limit_ma_o <= `FDM_VALLEY_LIMIT_SELECT_DIRECT_LO;
		end else begin
			valley_limit_ma_o <= nxt_valley_limit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// over-voltage threshold and LED failure handling
	logic nxt_ovp_high;

	assign nxt_ovp_high = storage_cap_mode_input_i ||
		(output_voltage_code_ff > `FDM_OV_LOW_MAX);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovp_high_sel_o <= 1'b0;
			overvoltage_clamp_o <= 1'b0;
			sink_limit_o <= 1'b0;
			led_failure_flag_o <= 1'b0;
		end else begin
			ovp_high_sel_o <= nxt_ovp_high;
			overvoltage_clamp_o <= led_open_i && !nxt_shutdown;
			sink_limit_o <= led_short_i && !nxt_shutdown;
			led_failure_flag_o <= led_short_i || led_open_i ||
				irq_status_ff[`FDM_EV_SHORT] || irq_status_ff[`FDM_EV_OPEN];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read, data in the cycle after the strobe
	logic [31:0] nxt_rdata;

	always_comb begin
		nxt_rdata = 32'h0;
		unique case (addr_i)
			`FDM_OFF_CTRL: begin
				nxt_rdata[`FDM_CTRL_MODE_LSB +: 2] = mode_ff;
				nxt_rdata[`FDM_CTRL_FORCE_BIT] = force_voltage_regulation_ff;
				nxt_rdata[`FDM_CTRL_LIMIT_BIT] = valley_limit_select_ff;
				nxt_rdata[`FDM_CTRL_DUR_LSB +: 3] = flash_duration_field_ff;
			end
			`FDM_OFF_VOUT: begin
				nxt_rdata[3:0] = output_voltage_code_ff;
			end
			`FDM_OFF_STATE: begin
				nxt_rdata[0] = led_failure_flag_o;
				nxt_rdata[1] = flash_drive_o;
				nxt_rdata[2] = initial_shutdown_ff;
				nxt_rdata[3] = stage_enable_o;
				nxt_rdata[4] = ovp_high_sel_o;
				nxt_rdata[5] = current_regulation_mode_o;
				nxt_rdata[6] = voltage_regulation_mode_o;
			end
			`FDM_OFF_IRQ_STATUS: begin
				nxt_rdata[`FDM_EV_W-1:0] = irq_status_ff;
			end
			`FDM_OFF_IRQ_ENABLE: begin
				nxt_rdata[`FDM_EV_W-1:0] = irq_enable_ff;
			end
			default: begin
				nxt_rdata = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_ff <= 32'h0;
		end else if (rd_i) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h0;
		end
	end

	assign rdata_o = rdata_ff;
endmodule : fdm_top
`default_nettype wire

// [tb/fdm_led_model.sv]
`default_nettype none
module fdm_led_model (
	input wire logic led_enable_i, // sinks on
	input wire logic short_i, // inject short
	input wire logic open_i, // inject open
	output logic short_o, // short sensed
	output logic open_o // open sensed
);
	timeunit 1ns;
	timeprecision 1ps;
	// a failed led only shows while the sinks draw current
	assign short_o = led_enable_i & short_i;
	assign open_o = led_enable_i & open_i;
endmodule : fdm_led_model
`default_nettype wire

// [tb/fdm_top_monitor.sv]
`include "fdm_map.svh"
`default_nettype none
module fdm_top_monitor (
	input wire logic clock_i, // clock
	input wire logic rstn_i, // reset
	input wire logic storage_cap_mode_input_i, // watched
	input wire logic blank_i, // watched
	input wire logic led_short_i, // watched
	input wire logic led_open_i, // watched
	input wire logic shutdown_o, // watched
	input wire logic load_connect_o, // watched
	input wire logic current_regulation_mode_o, // watched
	input wire logic voltage_regulation_mode_o, // watched
	input wire logic led_enable_o, // watched
	input wire logic flash_armed_o, // watched
	input wire logic flash_drive_o, // watched
	input wire logic stage_enable_o, // watched
	input wire logic [`FDM_VALLEY_LIMIT_SELECT_W-1:0] valley_limit_ma_o, // watched
	input wire logic ovp_high_sel_o, // watched
	input wire logic led_failure_flag_o // watched
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_shut_idle: assert property (shutdown_o |-> !load_connect_o
		&& !current_regulation_mode_o && !voltage_regulation_mode_o) else $error("shutdown active");
	a_mode_excl: assert property (voltage_regulation_mode_o |-> !current_regulation_mode_o)
		else $error("both regulation modes");
	a_limit_direct: assert property ($past(rstn_i) && !$past(storage_cap_mode_input_i) |->
		valley_limit_ma_o inside {`FDM_VALLEY_LIMIT_SELECT_DIRECT_LO, `FDM_VALLEY_LIMIT_SELECT_DIRECT_HI}) else $error("direct limit");
	a_limit_store: assert property ($past(rstn_i) &&
		$past(storage_cap_mode_input_i && !blank_i) |->
		valley_limit_ma_o inside {`FDM_VALLEY_LIMIT_SELECT_STORE_LO, `FDM_VALLEY_LIMIT_SELECT_STORE_HI}) else $error("store limit");
	a_stage_blank: assert property ($past(rstn_i) &&
		$past(storage_cap_mode_input_i && blank_i) |->
		valley_limit_ma_o == `FDM_VALLEY_LIMIT_SELECT_NONE && !stage_enable_o) else $error("stage not off");
	a_ovp_store: assert property ($past(rstn_i && storage_cap_mode_input_i) |->
		ovp_high_sel_o) else $error("ovp threshold low");
	a_short_flag: assert property ($past(rstn_i && led_short_i) |->
		led_failure_flag_o) else $error("short not flagged");
	a_open_flag: assert property ($past(rstn_i && led_open_i) |->
		led_failure_flag_o) else $error("open not flagged");
	a_drive_armed: assert property ($rose(flash_drive_o) |-> flash_armed_o)
		else $error("drive unarmed");
	a_armed_sink: assert property (flash_armed_o |-> led_enable_o)
		else $error("armed without sinks");
endmodule : fdm_top_monitor
bind fdm_top fdm_top_monitor i_mon (
	.clock_i(clock_i),
	.rstn_i(rstn_i),
	.storage_cap_mode_input_i(storage_cap_mode_input_i),
	.blank_i(blank_i),
	.led_short_i(led_short_i),
	.led_open_i(led_open_i),
	.shutdown_o(shutdown_o),
	.load_connect_o(load_connect_o),
	.current_regulation_mode_o(current_regulation_mode_o),
	.voltage_regulation_mode_o(voltage_regulation_mode_o),
	.led_enable_o(led_enable_o),
	.flash_armed_o(flash_armed_o),
	.flash_drive_o(flash_drive_o),
	.stage_enable_o(stage_enable_o),
	.valley_limit_ma_o(valley_limit_ma_o),
	.ovp_high_sel_o(ovp_high_sel_o),
	.led_failure_flag_o(led_failure_flag_o)
);
`default_nettype wire

// [tb/tb_fdm_top.sv]
`include "fdm_map.svh"
`default_nettype none
module tb_fdm_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'h0, rstn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o;
	logic storage_cap_mode_input_i = 1'h0, blank_i = 1'h0, strobe_i = 1'h0;
	logic short_cmd = 1'h0, open_cmd = 1'h0, sd, vm, stg;
	wire logic led_short_i, led_open_i;
	logic shutdown_o, load_connect_o, current_regulation_mode_o, voltage_regulation_mode_o;
	logic led_enable_o, flash_armed_o, flash_drive_o, stage_enable_o, ovp_high_sel_o;
	logic overvoltage_clamp_o, sink_limit_o, led_failure_flag_o, irq_o;
	logic [10:0] valley_limit_ma_o;
	logic [3:0] m;
	int bad_count = 0, n_checks = 0, len;
	always #5 clock_i = ~clock_i;
	fdm_top i_dut (.*);
	fdm_led_model i_led (.led_enable_i(led_enable_o), .short_i(short_cmd), .open_i(open_cmd),
		.short_o(led_short_i), .open_o(led_open_i));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h got %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'h1;
		@(posedge clock_i);
		wr_i <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clock_i);
		rd_i <= 1'h0;
		#1 chk(s, e, rdata_o);
	endtask : rd
	task automatic st;
		repeat (3) @(posedge clock_i);
		#1;
	endtask : st
	task automatic drv(input logic s, input logic b);
		@(posedge clock_i);
		storage_cap_mode_input_i <= s;
		blank_i <= b;
		st;
	endtask : drv
	task automatic pulse(input logic o);
		@(posedge clock_i);
		short_cmd <= !o;
		open_cmd <= o;
		repeat (2) @(posedge clock_i);
		#1 chk("fail_out", 2'h3, {o ? overvoltage_clamp_o : sink_limit_o, led_failure_flag_o});
		@(posedge clock_i);
		short_cmd <= 1'h0;
		open_cmd <= 1'h0;
		st;
	endtask : pulse
	// strobe held until the safety timer ends the drive
	task automatic flash;
		@(posedge clock_i);
		strobe_i <= 1'h1;
		len = 0;
		repeat (4) @(posedge clock_i);
		#1 stg = stage_enable_o;
		while (flash_drive_o === 1'h1 && len < 12000) begin
			@(posedge clock_i);
			#1 len++;
		end
		@(posedge clock_i);
		strobe_i <= 1'h0;
		st;
	endtask : flash
	task automatic finish_test;
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#400us;
		bad_count++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge clock_i);
		#1 chk("rst", {1'h1, 11'h47e}, {shutdown_o, valley_limit_ma_o});
		@(posedge clock_i);
		rstn_i <= 1'h1;
		drv(1'h1, 1'h0);
		chk("valley", 11'h01e, valley_limit_ma_o);
		drv(1'h0, 1'h1);
		chk("valley", 11'h47e, valley_limit_ma_o);
		wr(8'h00, 32'h8);
		st;
		chk("valley", 11'h640, valley_limit_ma_o);
		for (int i = 1; i <= 8; i++) begin
			m = {1'h1, i[2:0]};
			wr(8'h00, {28'h0, m});
			st;
			sd = m[1:0] == 2'h0 && !m[2];
			vm = m[2] || m[1:0] == 2'h3;
			chk("modes", {sd, !sd, !sd && !vm, vm, m[1] ^ m[0], m[1:0] == 2'h2},
				{shutdown_o, load_connect_o, current_regulation_mode_o, voltage_regulation_mode_o,
				led_enable_o, flash_armed_o});
		end
		wr(8'h00, 32'h1);
		st;
		chk("valley", 11'h640, valley_limit_ma_o);
		drv(1'h0, 1'h0);
		wr(8'h04, 32'h4);
		st;
		chk("ovp", 1'h0, ovp_high_sel_o);
		wr(8'h04, 32'h5);
		st;
		chk("ovp", 1'h1, ovp_high_sel_o);
		rd(8'h04, 32'h5, "vout");
		wr(8'h04, 32'h0);
		drv(1'h1, 1'h0);
		chk("ovp_lim", {1'h1, 11'h0fa}, {ovp_high_sel_o, valley_limit_ma_o});
		drv(1'h1, 1'h1);
		chk("stage", {1'h0, 11'h000}, {stage_enable_o, valley_limit_ma_o});
		drv(1'h0, 1'h0);
		wr(8'h14, 32'h1);
		pulse(1'h0);
		chk("irq", 1'h1, irq_o);
		rd(8'h0c, 32'h1, "status");
		pulse(1'h1);
		rd(8'h0c, 32'h3, "status");
		wr(8'h10, 32'h1);
		st;
		chk("irq", 1'h0, irq_o);
		rd(8'h0c, 32'h2, "status");
		wr(8'h10, 32'h2);
		st;
		chk("flag", 1'h0, led_failure_flag_o);
		rd(8'h14, 32'h1, "enable");
		rd(8'h10, 32'h0, "clear_reg");
		rd(8'h40, 32'h0, "unmapped");
		drv(1'h1, 1'h0);
		wr(8'h00, 32'h2);
		st;
		rd(8'h00, 32'ha, "ctrl");
		flash;
		chk("stage_cm", 1'h0, stg);
		chk("len_ok", 1'h1, len > 4900 && len < 5050);
		rd(8'h0c, 32'h4, "status");
		rd(8'h08, 32'h38, "state");
		wr(8'h10, 32'h4);
		wr(8'h00, 32'h16);
		st;
		flash;
		chk("stage_vm", 1'h1, stg);
		chk("len_two", 1'h1, len > 9900 && len < 10050);
		wr(8'h10, 32'h4);
		@(posedge clock_i);
		strobe_i <= 1'h1;
		repeat (6) @(posedge clock_i);
		strobe_i <= 1'h0;
		st;
		chk("abort", 1'h0, flash_drive_o);
		rd(8'h0c, 32'h0, "status");
		// second reset in mid-run re-opens the initial shutdown window
		@(posedge clock_i);
		rstn_i <= 1'h0;
		st;
		chk("rst2", {1'h1, 11'h47e}, {shutdown_o, valley_limit_ma_o});
		@(posedge clock_i);
		rstn_i <= 1'h1;
		rd(8'h08, 32'h14, "state");
		wr(8'h00, 32'h8);
		rd(8'h00, 32'h8, "ctrl");
		finish_test;
	end
endmodule : tb_fdm_top
`default_nettype wire
